// ==== design/flag_regs.svh ====
`ifndef FLAG_REGS_SVH
`define FLAG_REGS_SVH

// register byte offsets, low address byte
`define OFS_OP 8'h00
`define OFS_OPA 8'h04
`define OFS_OPB 8'h08
`define OFS_RES 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_IEL 8'h14
`define OFS_TST 8'h18

// reset values
`define RST_FLAGS 8'h00
`define RST_WORD 16'h0000
`define RST_IEL 1'b0
`define RST_TST 32'h0000_0000

// one T state per core clock period
`define T_STEP 32'h0000_0001

// packed bcd correction
`define BCD_DIGIT_MAX 4'h9
`define BCD_BYTE_MAX 8'h99
`define BCD_FIX 4'h6
`define BCD_SUB_LIM 4'h6

`endif

// ==== design/flag_pkg.sv ====
`default_nettype none
package flag_pkg;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_ADD = 5'h01,
        OP_ADC = 5'h02,
        OP_SUB = 5'h03,
        OP_SBC = 5'h04,
        OP_CP = 5'h05,
        OP_NEG = 5'h06,
        OP_AND = 5'h07,
        OP_OR = 5'h08,
        OP_XOR = 5'h09,
        OP_INC = 5'h0A,
        OP_DEC = 5'h0B,
        OP_ADD16 = 5'h0C,
        OP_ADC16 = 5'h0D,
        OP_SBC16 = 5'h0E,
        OP_BCD_ADJ = 5'h0F,
        OP_CPL = 5'h10,
        OP_SCF = 5'h11,
        OP_CCF = 5'h12,
        OP_LDAIR = 5'h13
    } alu_op_t;

    // bit 7 down to bit 0 of the flag register
    typedef struct packed {
        logic s;
        logic z;
        logic y5;
        logic h;
        logic x3;
        logic pv;
        logic n;
        logic c;
    } flags_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } ahb_rsp_t;

endpackage
`default_nettype wire

// ==== design/cpu_condition_flag_logic.sv ====
// What this block does
// [RULE_01] carry set on carry out of msb
// [RULE_02] zero set when result is all zero
// [RULE_03] sign follows result msb
// [RULE_04] shared bit: parity for logic, overflow arithmetic
// [RULE_05] parity one for even bit count
// [RULE_06] overflow one on signed range overflow
// [RULE_07] half carry from bit three into four
// [RULE_08] subtract mark set after subtract operations
// [RULE_09] decimal adjust uses half carry, subtract mark
// [RULE_10] byte operands 0..255, word operands 0..65535
// [RULE_11] time counted in T states, one clock
// [RULE_12] load from i or r copies enable latch
// [RULE_13] non flag operations leave flags alone
// [RULE_14] unaffected flags kept, reset/set flags forced
`include "flag_regs.svh"
`default_nettype none
module cpu_condition_flag_logic (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // ahb-lite slave
    input wire flag_pkg::ahb_req_t i_ahb,
    output var flag_pkg::ahb_rsp_t o_ahb,
    // toward the datapath
    output var flag_pkg::flags_t o_flags,
    output var logic [15:0] o_result
);
    import flag_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    logic [15:0] opa_q;
    logic [15:0] opb_q;
    logic [15:0] res_q;
    flags_t flags_q;
    logic iel_q;
    alu_op_t op_q;
    logic [31:0] tst_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic hit_q;
    logic [7:0] addr_q;
    logic hready_q;
    logic [31:0] rdata_q;
    flags_t nf;
    logic [15:0] nr;

    ////////////////////////////////////////////////////////////////////
    // bus decode
    wire ahb_go = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1];
    wire in_map = (i_ahb.haddr[31:8] == 24'h000000);
    wire wr_en = wr_pend_q & hit_q;
    wire exec = wr_en & (addr_q == `OFS_OP);
    wire wr_opa = wr_en & (addr_q == `OFS_OPA);
    wire wr_opb = wr_en & (addr_q == `OFS_OPB);
    wire wr_flags = wr_en & (addr_q == `OFS_FLAGS);
    wire wr_iel = wr_en & (addr_q == `OFS_IEL);
    wire alu_op_t op_w = alu_op_t'(i_ahb.hwdata[4:0]);
    wire [31:0] rd_mux =
        !hit_q ? 32'h0000_0000 :
        addr_q == `OFS_OP ? {27'h0000000, op_q} :
        addr_q == `OFS_OPA ? {16'h0000, opa_q} :
        addr_q == `OFS_OPB ? {16'h0000, opb_q} :
        addr_q == `OFS_RES ? {16'h0000, res_q} :
        addr_q == `OFS_FLAGS ? {24'h000000, flags_q} :
        addr_q == `OFS_IEL ? {31'h00000000, iel_q} :
        addr_q == `OFS_TST ? tst_q : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // 8-bit arithmetic
    wire [7:0] a8 = opa_q[7:0]; // RULE_10
    wire [7:0] b8 = opb_q[7:0];
    wire is_neg = (op_w == OP_NEG);
    wire is_step = (op_w == OP_INC) | (op_w == OP_DEC);
    wire ci8 = flags_q.c & ((op_w == OP_ADC) | (op_w == OP_SBC));
    wire ci16 = flags_q.c & ((op_w == OP_ADC16) | (op_w == OP_SBC16));
    wire [7:0] xa = is_neg ? 8'h00 : a8;
    wire [7:0] xb = is_step ? 8'h01 : (is_neg ? a8 : b8);
    wire [8:0] add9 = {1'b0, xa} + {1'b0, xb} + {8'h00, ci8};
    wire [8:0] sub9 = {1'b0, xa} - {1'b0, xb} - {8'h00, ci8};
    wire [4:0] hadd = {1'b0, xa[3:0]} + {1'b0, xb[3:0]} + {4'h0, ci8};
    wire [4:0] hsub = {1'b0, xa[3:0]} - {1'b0, xb[3:0]} - {4'h0, ci8};
    wire vadd = (xa[7] == xb[7]) & (add9[7] != xa[7]);
    wire vsub = (xa[7] != xb[7]) & (sub9[7] != xa[7]);

    ////////////////////////////////////////////////////////////////////
    // 16-bit arithmetic
    wire [16:0] add17 = {1'b0, opa_q} + {1'b0, opb_q} + {16'h0000, ci16};
    wire [16:0] sub17 = {1'b0, opa_q} - {1'b0, opb_q} - {16'h0000, ci16};
    wire [12:0] h16a = {1'b0, opa_q[11:0]} + {1'b0, opb_q[11:0]}
        + {12'h000, ci16};
    wire [12:0] h16s = {1'b0, opa_q[11:0]} - {1'b0, opb_q[11:0]}
        - {12'h000, ci16};
    wire v16a = (opa_q[15] == opb_q[15]) & (add17[15] != opa_q[15]);
    wire v16s = (opa_q[15] != opb_q[15]) & (sub17[15] != opa_q[15]);

    ////////////////////////////////////////////////////////////////////
    // packed bcd correction
    wire lo_fix = flags_q.h | (a8[3:0] > `BCD_DIGIT_MAX); // RULE_09
    wire hi_fix = flags_q.c | (a8 > `BCD_BYTE_MAX); // RULE_09
    wire [7:0] corr = {hi_fix ? `BCD_FIX : 4'h0, lo_fix ? `BCD_FIX : 4'h0};
    wire [7:0] adj_r = flags_q.n ? a8 - corr : a8 + corr; // RULE_09
    wire adj_h = flags_q.n ? (flags_q.h & (a8[3:0] < `BCD_SUB_LIM))
        : (a8[3:0] > `BCD_DIGIT_MAX);

    ////////////////////////////////////////////////////////////////////
    // flag selection per operation
    always_comb begin
        logic [7:0] r8;
        logic wr8;
        logic zs8;
        r8 = 8'h00;
        wr8 = 1'b0;
        zs8 = 1'b0;
        nf = flags_q; // RULE_14
        nr = res_q;
        unique case (op_w)
            OP_ADD, OP_ADC, OP_INC: begin
                r8 = add9[7:0];
                wr8 = 1'b1;
                zs8 = 1'b1;
                nf.h = hadd[4]; // RULE_07
                nf.pv = vadd; // RULE_04 RULE_06
                nf.n = 1'b0;
                if (op_w != OP_INC) begin
                    nf.c = add9[8]; // RULE_01
                end
            end
            OP_SUB, OP_SBC, OP_CP, OP_NEG, OP_DEC: begin
                r8 = sub9[7:0];
                wr8 = (op_w != OP_CP);
                zs8 = 1'b1;
                nf.h = hsub[4]; // RULE_07
                nf.pv = vsub; // RULE_06
                nf.n = 1'b1; // RULE_08
                if (op_w != OP_DEC) begin
                    nf.c = sub9[8]; // RULE_01
                end
            end
            OP_AND, OP_OR, OP_XOR: begin
                r8 = (op_w == OP_AND) ? a8 & b8 :
                    (op_w == OP_OR) ? a8 | b8 : a8 ^ b8;
                wr8 = 1'b1;
                zs8 = 1'b1;
                nf.c = 1'b0;
                nf.h = (op_w == OP_AND);
                nf.n = 1'b0;
                nf.pv = ~^r8; // RULE_04 RULE_05
            end
            OP_ADD16: begin
                nr = add17[15:0];
                nf.c = add17[16]; // RULE_01
                nf.h = h16a[12];
                nf.n = 1'b0;
            end
            OP_ADC16, OP_SBC16: begin
                nr = (op_w == OP_ADC16) ? add17[15:0] : sub17[15:0];
                nf.c = (op_w == OP_ADC16) ? add17[16] : sub17[16];
                nf.h = (op_w == OP_ADC16) ? h16a[12] : h16s[12];
                nf.pv = (op_w == OP_ADC16) ? v16a : v16s; // RULE_06
                nf.n = (op_w == OP_SBC16); // RULE_08
                nf.z = (nr == 16'h0000); // RULE_02
                nf.s = nr[15]; // RULE_03
            end
            OP_BCD_ADJ: begin
                r8 = adj_r;
                wr8 = 1'b1;
                zs8 = 1'b1;
                nf.c = hi_fix; // RULE_09
                nf.h = adj_h; // RULE_09
                nf.pv = ~^adj_r; // RULE_05
            end
            OP_CPL: begin
                r8 = ~a8;
                wr8 = 1'b1;
                nf.n = 1'b1;
                nf.h = 1'b1;
            end
            OP_SCF: begin
                nf.c = 1'b1; // RULE_14
                nf.n = 1'b0;
                nf.h = 1'b0;
            end
            OP_CCF: begin
                nf.h = flags_q.c;
                nf.c = ~flags_q.c;
                nf.n = 1'b0;
            end
            OP_LDAIR: begin
                r8 = a8;
                wr8 = 1'b1;
                zs8 = 1'b1;
                nf.pv = iel_q; // RULE_12
                nf.n = 1'b0;
                nf.h = 1'b0;
            end
            OP_NOP: begin
                nf = flags_q; // RULE_13
            end
            default: begin
                nf = flags_q; // RULE_13
            end
        endcase
        if (zs8) begin
            nf.z = (r8 == 8'h00); // RULE_02
            nf.s = r8[7]; // RULE_03
        end
        if (wr8) begin
            nr = {8'h00, r8}; // RULE_10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus slave: writes zero wait, reads one wait state
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            hit_q <= 1'b0;
            addr_q <= 8'h00;
            hready_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            hready_q <= 1'b1;
            rdata_q <= rd_mux;
        end else begin
            wr_pend_q <= ahb_go & i_ahb.hwrite;
            rd_pend_q <= ahb_go & ~i_ahb.hwrite;
            hready_q <= ~(ahb_go & ~i_ahb.hwrite);
            hit_q <= ahb_go & in_map;
            addr_q <= ahb_go ? i_ahb.haddr[7:0] : addr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // operand, result and flag registers
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            opa_q <= `RST_WORD;
            opb_q <= `RST_WORD;
            res_q <= `RST_WORD;
            flags_q <= flags_t'(`RST_FLAGS);
            iel_q <= `RST_IEL;
            op_q <= OP_NOP;
            tst_q <= `RST_TST;
        end else begin
            tst_q <= tst_q + `T_STEP; // RULE_11
            opa_q <= wr_opa ? i_ahb.hwdata[15:0] : opa_q; // RULE_10
            opb_q <= wr_opb ? i_ahb.hwdata[15:0] : opb_q; // RULE_10
            iel_q <= wr_iel ? i_ahb.hwdata[0] : iel_q;
            op_q <= exec ? op_w : op_q;
            res_q <= exec ? nr : res_q;
            if (exec) begin
                flags_q <= nf;
            end else if (wr_flags) begin
                flags_q <= flags_t'(i_ahb.hwdata[7:0]);
            end
        end
    end

    assign o_ahb = {hready_q, 1'b0, rdata_q};
    assign o_flags = flags_q;
    assign o_result = res_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    carry_add_a: // RULE_01
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_ADD |=> flags_q.c == $past(add9[8]))
        else $error("carry not taken from bit 7 sum");

    zero_sub_a: // RULE_02
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_SUB |=> flags_q.z == (res_q[7:0] == 8'h00))
        else $error("zero flag does not match result");

    sign_and_a: // RULE_03
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_AND |=> flags_q.s == res_q[7])
        else $error("sign flag does not match result msb");

    parity_xor_a: // RULE_05
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_XOR |=> flags_q.pv == ~^res_q[7:0])
        else $error("parity flag wrong after logic op");

    overflow_add_a: // RULE_06
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_ADD |=> flags_q.pv ==
            (($past(a8[7]) == $past(b8[7])) && res_q[7] != $past(a8[7])))
        else $error("overflow flag wrong after add");

    half_add_a: // RULE_07
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_ADD |=> flags_q.h ==
            (({1'b0, $past(a8[3:0])} + {1'b0, $past(b8[3:0])}) > 5'h0F))
        else $error("half carry wrong after add");

    sub_mark_a: // RULE_08
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && (op_w == OP_SUB || op_w == OP_DEC) |=> flags_q.n)
        else $error("subtract mark not set");

    bcd_fix_a: // RULE_09
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_BCD_ADJ && a8 == 8'h0A && flags_q[4:0] == 5'h00
            |=> res_q == 16'h0010 && !flags_q.c)
        else $error("decimal adjust wrong for 0A");

    word_wrap_a: // RULE_10
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_ADD16 && opa_q == 16'hFFFF && opb_q == 16'h0001
            |=> res_q == 16'h0000 && flags_q.c)
        else $error("word add does not wrap at 65535");

    tstate_step_a: // RULE_11
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            !i_sys_rst |=> tst_q == $past(tst_q) + `T_STEP)
        else $error("T state count missed a clock");

    iel_copy_a: // RULE_12
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_LDAIR |=> flags_q.pv == $past(iel_q))
        else $error("enable latch not copied to pv");

    nop_keep_a: // RULE_13
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_NOP |=> $stable(flags_q))
        else $error("flags changed by non flag op");

    scf_force_a: // RULE_14
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            exec && op_w == OP_SCF |=> flags_q.c && !flags_q.n && !flags_q.h
            && flags_q.z == $past(flags_q.z))
        else $error("set carry did not force or keep flags");

    read_wait_a:
        assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
            ahb_go && !i_ahb.hwrite |=> !hready_q ##1 hready_q)
        else $error("read did not take one wait state");

endmodule
`default_nettype wire

// ==== test/tb_cpu_condition_flag_logic.sv ====
`include "flag_regs.svh"
`default_nettype none
module tb_cpu_condition_flag_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import flag_pkg::*;

    `define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
        bad_count++; $display("unexpected %s exp %h got %h", nm, ex, got); \
        end end

    localparam logic [31:0] A_OP = {24'h0, `OFS_OP};
    localparam logic [31:0] A_OPA = {24'h0, `OFS_OPA};
    localparam logic [31:0] A_OPB = {24'h0, `OFS_OPB};
    localparam logic [31:0] A_RES = {24'h0, `OFS_RES};
    localparam logic [31:0] A_FLG = {24'h0, `OFS_FLAGS};
    localparam logic [31:0] A_IEL = {24'h0, `OFS_IEL};
    localparam logic [31:0] A_TST = {24'h0, `OFS_TST};

    logic core_clk;
    logic sys_rst;
    logic m_sel;
    logic m_write;
    logic [1:0] m_trans;
    logic [31:0] m_addr;
    logic [31:0] m_wdata;
    logic [31:0] rd_q;
    logic [31:0] t0;
    ahb_req_t req;
    ahb_rsp_t rsp;
    flags_t flags;
    logic [15:0] result;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;

    // the one slave's hreadyout is the bus hready
    assign req = {m_sel, m_addr, m_trans, m_write, 3'h2, m_wdata,
        rsp.hreadyout};

    cpu_condition_flag_logic dut_u (
        .i_core_clk(core_clk),
        .i_sys_rst(sys_rst),
        .i_ahb(req),
        .o_ahb(rsp),
        .o_flags(flags),
        .o_result(result)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // hready is looked at in the low half, where the flop has settled
    task automatic wait_ready();
        @(negedge core_clk);
        while (rsp.hreadyout !== 1'b1) begin
            @(negedge core_clk);
        end
        rd_q = rsp.hrdata;
        @(posedge core_clk);
    endtask

    task automatic bus(input logic wr, input logic [31:0] a,
        input logic [31:0] d);
        m_sel <= 1'b1;
        m_trans <= 2'h2;
        m_addr <= a;
        m_write <= wr;
        wait_ready();
        m_trans <= 2'h0;
        m_wdata <= d;
        wait_ready();
    endtask

    // y5 and x3 are masked: their value after an operation is free
    task automatic run(input logic [4:0] op, input logic [7:0] pre,
        input logic [15:0] a, input logic [15:0] b, input logic [7:0] ef,
        input logic [15:0] er, input logic cr);
        bus(1'b1, A_FLG, {24'h0, pre});
        bus(1'b1, A_OPA, {16'h0, a});
        bus(1'b1, A_OPB, {16'h0, b});
        bus(1'b1, A_OP, {27'h0, op});
        bus(1'b0, A_FLG, 32'h0);
        `CHK("flags reg", ef & 8'hD7, rd_q[7:0] & 8'hD7)
        `CHK("flags port", ef & 8'hD7, flags & 8'hD7)
        if (cr) begin
            bus(1'b0, A_RES, 32'h0);
            `CHK("result reg", {16'h0, er}, rd_q)
            `CHK("result port", er, result)
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_arith();
        run(OP_ADD, 8'h00, 16'h7F, 16'h01, 8'h94, 16'h80, 1'b1);
        run(OP_ADD, 8'h00, 16'hFF, 16'h01, 8'h51, 16'h00, 1'b1);
        run(OP_ADC, 8'h01, 16'h0E, 16'h01, 8'h10, 16'h10, 1'b1);
        run(OP_SUB, 8'h00, 16'h80, 16'h01, 8'h16, 16'h7F, 1'b1);
        run(OP_SBC, 8'h01, 16'h00, 16'h00, 8'h93, 16'hFF, 1'b1);
        run(OP_CP, 8'h00, 16'h05, 16'h05, 8'h42, 16'hFF, 1'b1);
        run(OP_NEG, 8'h00, 16'h01, 16'h00, 8'h93, 16'hFF, 1'b1);
        run(OP_INC, 8'h01, 16'h7F, 16'h00, 8'h95, 16'h80, 1'b1);
        run(OP_DEC, 8'h00, 16'h80, 16'h00, 8'h16, 16'h7F, 1'b1);
    endtask

    task automatic t_logic();
        run(OP_AND, 8'h01, 16'hF0, 16'h3C, 8'h14, 16'h30, 1'b1);
        run(OP_OR, 8'h13, 16'h80, 16'h01, 8'h84, 16'h81, 1'b1);
        run(OP_XOR, 8'h04, 16'h07, 16'h00, 8'h00, 16'h07, 1'b1);
    endtask

    task automatic t_word();
        run(OP_ADD16, 8'hC6, 16'hFFFF, 16'h1, 8'hD5, 16'h0, 1'b1);
        run(OP_ADC16, 8'h01, 16'h7FFF, 16'h0, 8'h94, 16'h8000, 1'b1);
        run(OP_SBC16, 8'h00, 16'h0, 16'h1, 8'h93, 16'hFFFF, 1'b1);
    endtask

    task automatic t_bcd();
        run(OP_ADD, 8'h00, 16'h15, 16'h27, 8'h00, 16'h3C, 1'b1);
        run(OP_BCD_ADJ, 8'h00, 16'h3C, 16'h00, 8'h14, 16'h42, 1'b1);
        run(OP_BCD_ADJ, 8'h12, 16'h0F, 16'h00, 8'h06, 16'h09, 1'b1);
        run(OP_BCD_ADJ, 8'h00, 16'h0A, 16'h00, 8'h10, 16'h10, 1'b1);
        run(OP_BCD_ADJ, 8'h00, 16'h9A, 16'h00, 8'h55, 16'h00, 1'b1);
    endtask

    task automatic t_misc();
        run(OP_CPL, 8'hC5, 16'h0F, 16'h00, 8'hD7, 16'hF0, 1'b1);
        run(OP_SCF, 8'h12, 16'h00, 16'h00, 8'h01, 16'h00, 1'b0);
        run(OP_CCF, 8'h03, 16'h00, 16'h00, 8'h10, 16'h00, 1'b0);
        bus(1'b1, A_IEL, 32'h1);
        run(OP_LDAIR, 8'h01, 16'h00, 16'h00, 8'h45, 16'h00, 1'b1);
        bus(1'b1, A_IEL, 32'h0);
        run(OP_LDAIR, 8'h04, 16'h80, 16'h00, 8'h80, 16'h80, 1'b1);
        bus(1'b1, A_RES, 32'hAAAA);
        bus(1'b0, A_RES, 32'h0);
        `CHK("res read only", 32'h80, rd_q)
    endtask

    task automatic t_regs();
        run(OP_NOP, 8'hFF, 16'h00, 16'h00, 8'hFF, 16'h00, 1'b0);
        `CHK("flags kept", 8'hFF, flags)
        bus(1'b1, A_OP, 32'h15);
        bus(1'b0, A_FLG, 32'h0);
        `CHK("flags no op", 32'hFF, rd_q)
        `CHK("result no op", 16'h80, result)
        bus(1'b0, A_OP, 32'h0);
        `CHK("op readback", 32'h15, rd_q)
        bus(1'b0, 32'h1C, 32'h0);
        `CHK("unmapped low", 32'h0, rd_q)
        bus(1'b0, 32'h100, 32'h0);
        `CHK("unmapped high", 32'h0, rd_q)
        `CHK("okay resp", 1'b0, rsp.hresp)
        bus(1'b0, A_TST, 32'h0);
        t0 = rd_q;
        bus(1'b0, A_TST, 32'h0);
        `CHK("t state step", 32'h3, rd_q - t0)
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        m_sel = 1'b0;
        m_write = 1'b0;
        m_trans = 2'h0;
        m_addr = 32'h0;
        m_wdata = 32'h0;
        rd_q = 32'h0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        `CHK("flags reset", 8'h00, flags)
        `CHK("result reset", 16'h0, result)
        t_arith();
        t_logic();
        t_word();
        t_bcd();
        t_misc();
        t_regs();
        test_done();
    end
endmodule
`default_nettype wire
